// ==== hw/cgr_defs.svh ====
`ifndef CGR_DEFS_SVH
`define CGR_DEFS_SVH

// serial address (7-bit, write D2 / read D3 on the wire)
`define CGR_SLAVE_ADDR      7'h69
// count byte returned at the head of every read: bytes 0..7
`define CGR_READ_COUNT      8'h08
`define CGR_NUM_STORED      3'h6

// byte indices
`define CGR_IDX_SPREAD      8'h00
`define CGR_IDX_MISC_EN     8'h01
`define CGR_IDX_GFX_REQB    8'h02
`define CGR_IDX_PCIE_EN     8'h03
`define CGR_IDX_REQ_AC      8'h04
`define CGR_IDX_VOLT_PCIE   8'h05
`define CGR_IDX_PART_ID     8'h06
`define CGR_IDX_REV_MAKER   8'h07

// reset values
`define CGR_RST_SPREAD      8'h00
`define CGR_RST_MISC_EN     8'hFF
`define CGR_RST_GFX_REQB    8'h30
`define CGR_RST_PCIE_EN     8'hFF
`define CGR_RST_REQ_AC      8'h00
`define CGR_RST_VOLT_PCIE   8'hA0

// writable bit masks; clear bits are reserved
`define CGR_WM_SPREAD       8'hFF
`define CGR_WM_MISC_EN      8'hFF
`define CGR_WM_GFX_REQB     8'h3A
`define CGR_WM_PCIE_EN      8'hF5
`define CGR_WM_REQ_AC       8'hE7
`define CGR_WM_VOLT_PCIE    8'hEF

// field positions
`define CGR_B0_ORIGIN       7
`define CGR_B0_GFX_SS       6
`define CGR_B0_PCIE_SS      5
`define CGR_B0_CPU_SS       4
`define CGR_B0_FS3          3
`define CGR_B2_GFX1         5
`define CGR_B2_GFX0         4
`define CGR_B2_REQB_P2      3
`define CGR_B2_REQB_P1      1
`define CGR_B4_REQA_P5      7
`define CGR_B4_REQA_P4      6
`define CGR_B4_REQA_P3      5
`define CGR_B4_REQC_G1      2
`define CGR_B4_REQC_G0      1
`define CGR_B4_REQC_P0      0

// bit counter marks
`define CGR_LAST_BIT        4'h7
`define CGR_BYTE_DONE       4'h8

`endif

// ==== hw/cgr_pkg.sv ====
package cgr_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_TACK = 5'h10
    } cgr_state_t;

    typedef enum logic [3:0] {
        ROLE_ADDR  = 4'h1,
        ROLE_INDEX = 4'h2,
        ROLE_COUNT = 4'h4,
        ROLE_DATA  = 4'h8
    } cgr_role_t;

    typedef struct packed {
        logic       usb_clock_one;
        logic       usb_clock_zero;
        logic       crystal_copy_two;
        logic       crystal_copy_one;
        logic       crystal_copy_zero;
        logic       link_clock_out;
        logic       processor_pair_one;
        logic       processor_pair_zero;
        logic       graphics_pair_one;
        logic       graphics_pair_zero;
        logic [5:0] pcie_ref_pair;
    } cgr_out_en_t;

    typedef struct packed {
        logic       freq_code_origin;
        logic       graphics_spread_on;
        logic       pcie_ref_spread_on;
        logic       processor_spread_on;
        logic [3:0] processor_freq_code;
        logic [3:0] active_freq_code;
        logic [2:0] output_voltage_code;
        logic [3:0] pcie_ref_freq_code;
    } cgr_cfg_t;

endpackage : cgr_pkg

// ==== hw/cgr_regs.sv ====
// Operation
// - byte0 bit7 picks pin or register codes
// - byte0 bits6-4 independent spread enables
// - byte0 cpu code, low bits from straps
// - byte1 eight output enables, reset one
// - byte2 graphics enables, reserved bits zero
// - byte2 maps second request to pcie1/2
// - byte3 pcie master enables override requests
// - byte4 maps first request to pcie3-5
// - byte4 maps third request to gfx, pcie0
// - byte5 voltage code resets to 101
// - byte5 pcie frequency code, reset zero
// - byte7 fixed revision and maker codes
// - block write: index, count, data bytes
// - block read: count then successive bytes
`timescale 1ns/10ps
`default_nettype none
`include "cgr_defs.svh"

module cgr_regs
    import cgr_pkg::*;
#(
    // identity values are arbitrary
    parameter logic [7:0] PART_ID    = 8'h5A,
    parameter logic [3:0] REV_CODE   = 4'h3,
    parameter logic [3:0] MAKER_CODE = 4'h7
)
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // serial register port, open drain data
    input  wire logic        smb_clk,
    input  wire logic        smb_dat_in,
    output logic             smb_dat_out,
    output logic             smb_dat_oe,
    // frequency select straps and clock requests
    input  wire logic [2:0]  freq_strap,
    input  wire logic        clock_request_first_n,
    input  wire logic        clock_request_second_n,
    input  wire logic        clock_request_third_n,
    // steering outputs
    output cgr_out_en_t      out_en,
    output cgr_cfg_t         cfg
);

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers

    logic [1:0]  scl_sync_q;
    logic [1:0]  sda_sync_q;
    logic        scl_prev_q;
    logic        sda_prev_q;
    logic [2:0]  req_m_q;
    logic [2:0]  req_s_q;
    logic [2:0]  strap_m_q;
    logic [2:0]  strap_s_q;

    // free-running so they are settled once reset has been held
    always_ff @(posedge clk_sys)
    begin
        scl_sync_q <= {scl_sync_q[0], smb_clk};
        sda_sync_q <= {sda_sync_q[0], smb_dat_in};
        scl_prev_q <= scl_sync_q[1];
        sda_prev_q <= sda_sync_q[1];
        req_m_q    <= {clock_request_third_n, clock_request_second_n, clock_request_first_n};
        req_s_q    <= req_m_q;
        strap_m_q  <= freq_strap;
        strap_s_q  <= strap_m_q;
    end

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl       = scl_sync_q[1];
    assign sda       = sda_sync_q[1];
    assign scl_rise  = scl & ~scl_prev_q;
    assign scl_fall  = ~scl & scl_prev_q;
    assign bus_start = scl & scl_prev_q & sda_prev_q & ~sda;
    assign bus_stop  = scl & scl_prev_q & ~sda_prev_q & sda;

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    logic [7:0]  regs_q [0:5];
    logic        strap_done_q;
    logic [2:0]  strap_latch_q;

    function automatic logic [7:0] wmask(input logic [7:0] idx);
        logic [7:0] m;
        m = 8'h00;
        unique case (idx)
            `CGR_IDX_SPREAD:    m = `CGR_WM_SPREAD;
            `CGR_IDX_MISC_EN:   m = `CGR_WM_MISC_EN;
            `CGR_IDX_GFX_REQB:  m = `CGR_WM_GFX_REQB;
            `CGR_IDX_PCIE_EN:   m = `CGR_WM_PCIE_EN;
            `CGR_IDX_REQ_AC:    m = `CGR_WM_REQ_AC;
            `CGR_IDX_VOLT_PCIE: m = `CGR_WM_VOLT_PCIE;
            default:            m = 8'h00;
        endcase
        return m;
    endfunction : wmask

    function automatic logic [7:0] rst_val(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `CGR_IDX_SPREAD:    v = `CGR_RST_SPREAD;
            `CGR_IDX_MISC_EN:   v = `CGR_RST_MISC_EN;
            `CGR_IDX_GFX_REQB:  v = `CGR_RST_GFX_REQB;
            `CGR_IDX_PCIE_EN:   v = `CGR_RST_PCIE_EN;
            `CGR_IDX_REQ_AC:    v = `CGR_RST_REQ_AC;
            `CGR_IDX_VOLT_PCIE: v = `CGR_RST_VOLT_PCIE;
            default:            v = 8'h00;
        endcase
        return v;
    endfunction : rst_val

    logic        wr_hit;
    logic [7:0]  wr_data;
    logic [7:0]  idx_q;

    // reset values, straps caught after release
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            for (int i = 0; i < 6; i++)
                regs_q[i] <= rst_val(8'(i));
            strap_done_q  <= 1'b0;
            strap_latch_q <= 3'h0;
        end
        else if (!strap_done_q)
        begin
            strap_done_q  <= 1'b1;
            strap_latch_q <= strap_s_q;
            regs_q[0]     <= {regs_q[0][7:3], strap_s_q};
        end
        else if (wr_hit && idx_q < {5'h00, `CGR_NUM_STORED})
        begin
            regs_q[idx_q[2:0]] <= (wr_data & wmask(idx_q)) | (rst_val(idx_q) & ~wmask(idx_q));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial slave engine

    cgr_state_t  st_q;
    cgr_role_t   role_q;
    logic [3:0]  bit_cnt_q;
    logic [7:0]  sr_q;
    logic        oe_q;
    logic        rd_q;
    logic        match_q;
    logic        nack_q;
    logic [7:0]  rx_byte;
    logic [7:0]  tx_next;
    localparam logic [7:0] READ_COUNT = `CGR_READ_COUNT;

    assign rx_byte = {sr_q[6:0], sda};
    assign tx_next = (idx_q == `CGR_IDX_PART_ID)        ? PART_ID :
                     (idx_q == `CGR_IDX_REV_MAKER)      ? {REV_CODE, MAKER_CODE} :
                     (idx_q < {5'h00, `CGR_NUM_STORED}) ? regs_q[idx_q[2:0]] : 8'h00;
    // data bytes are stored whatever count the host announced
    assign wr_hit  = (st_q == ST_RX) && scl_rise && (bit_cnt_q == `CGR_LAST_BIT) && (role_q == ROLE_DATA);
    assign wr_data = rx_byte;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st_q      <= ST_IDLE;
            role_q    <= ROLE_ADDR;
            bit_cnt_q <= 4'h0;
            sr_q      <= 8'h00;
            oe_q      <= 1'b0;
            rd_q      <= 1'b0;
            match_q   <= 1'b0;
            nack_q    <= 1'b0;
            idx_q     <= 8'h00;
        end
        else if (bus_stop)
        begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
        end
        // repeated start keeps the index for the read that follows
        else if (bus_start)
        begin
            st_q      <= ST_RX;
            role_q    <= ROLE_ADDR;
            bit_cnt_q <= 4'h0;
            oe_q      <= 1'b0;
            rd_q      <= 1'b0;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE: oe_q <= 1'b0;
                // address, index, count, data bytes in
                ST_RX:
                begin
                    if (scl_rise && bit_cnt_q < `CGR_BYTE_DONE)
                    begin
                        sr_q      <= rx_byte;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == `CGR_LAST_BIT)
                        begin
                            unique case (role_q)
                                ROLE_ADDR:
                                begin
                                    match_q <= (rx_byte[7:1] == `CGR_SLAVE_ADDR);
                                    rd_q    <= rx_byte[0];
                                end
                                ROLE_INDEX: idx_q <= rx_byte;
                                ROLE_COUNT: ;
                                ROLE_DATA:  idx_q <= idx_q + 8'h01;
                            endcase
                        end
                    end
                    else if (scl_fall && bit_cnt_q == `CGR_BYTE_DONE)
                    begin
                        bit_cnt_q <= 4'h0;
                        // foreign address: stay off the bus until the next start
                        if (role_q == ROLE_ADDR && !match_q)
                            st_q <= ST_IDLE;
                        else
                        begin
                            st_q <= ST_ACK;
                            oe_q <= 1'b1;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        // read address answered with the count byte
                        if (rd_q)
                        begin
                            st_q <= ST_TX;
                            sr_q <= `CGR_READ_COUNT;
                            oe_q <= ~READ_COUNT[7];
                        end
                        else
                        begin
                            st_q <= ST_RX;
                            oe_q <= 1'b0;
                            unique case (role_q)
                                ROLE_ADDR:  role_q <= ROLE_INDEX;
                                ROLE_INDEX: role_q <= ROLE_COUNT;
                                ROLE_COUNT: role_q <= ROLE_DATA;
                                ROLE_DATA:  role_q <= ROLE_DATA;
                            endcase
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_q == `CGR_LAST_BIT)
                        begin
                            st_q      <= ST_TACK;
                            oe_q      <= 1'b0;
                            bit_cnt_q <= 4'h0;
                        end
                        else
                        begin
                            sr_q      <= {sr_q[6:0], 1'b0};
                            oe_q      <= ~sr_q[6];
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                ST_TACK:
                begin
                    if (scl_rise)
                        nack_q <= sda;
                    else if (scl_fall)
                    begin
                        if (nack_q)
                            st_q <= ST_IDLE;
                        else
                        begin
                            st_q  <= ST_TX;
                            sr_q  <= tx_next;
                            oe_q  <= ~tx_next[7];
                            idx_q <= idx_q + 8'h01;
                        end
                    end
                end
            endcase
        end
    end

    // open drain: only ever pulls low
    assign smb_dat_out = 1'b0;
    assign smb_dat_oe  = oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // output steering

    logic [2:0]  req_on;
    logic [5:0]  pcie_map;
    logic [5:0]  pcie_req;

    assign req_on = ~req_s_q;

    // request bit per pcie pair, and whether that pair is mapped at all
    // request mapping per pair
    assign pcie_map = {regs_q[4][`CGR_B4_REQA_P5], regs_q[4][`CGR_B4_REQA_P4], regs_q[4][`CGR_B4_REQA_P3],
                       regs_q[2][`CGR_B2_REQB_P2], regs_q[2][`CGR_B2_REQB_P1], regs_q[4][`CGR_B4_REQC_P0]};
    assign pcie_req = {req_on[0], req_on[0], req_on[0], req_on[1], req_on[1], req_on[2]};

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            out_en <= '0;
        else
        begin
            {out_en.usb_clock_one, out_en.usb_clock_zero, out_en.crystal_copy_two, out_en.crystal_copy_one,
             out_en.crystal_copy_zero, out_en.link_clock_out, out_en.processor_pair_one,
             out_en.processor_pair_zero} <= regs_q[1];
            // graphics pairs gated by third request
            out_en.graphics_pair_one  <= regs_q[2][`CGR_B2_GFX1] & (~regs_q[4][`CGR_B4_REQC_G1] | req_on[2]);
            out_en.graphics_pair_zero <= regs_q[2][`CGR_B2_GFX0] & (~regs_q[4][`CGR_B4_REQC_G0] | req_on[2]);
            out_en.pcie_ref_pair <= {regs_q[3][7:4], regs_q[3][2], regs_q[3][0]} & (~pcie_map | pcie_req);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            cfg <= '0;
        else
        begin
            cfg.freq_code_origin    <= regs_q[0][`CGR_B0_ORIGIN];
            cfg.graphics_spread_on  <= regs_q[0][`CGR_B0_GFX_SS];
            cfg.pcie_ref_spread_on  <= regs_q[0][`CGR_B0_PCIE_SS];
            cfg.processor_spread_on <= regs_q[0][`CGR_B0_CPU_SS];
            cfg.processor_freq_code <= regs_q[0][3:0];
            // source select for the live code
            cfg.active_freq_code    <= regs_q[0][`CGR_B0_ORIGIN] ? regs_q[0][3:0] : {1'b0, strap_latch_q};
            cfg.output_voltage_code <= regs_q[5][7:5];
            cfg.pcie_ref_freq_code  <= regs_q[5][3:0];
        end
    end

endmodule : cgr_regs

`default_nettype wire

// ==== verif/cgr_regs_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module cgr_regs_checker
    import cgr_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        srst,
    // serial pins
    input wire logic        smb_clk,
    input wire logic        smb_dat_out,
    input wire logic        smb_dat_oe,
    // straps and steering outputs
    input wire logic [2:0]  freq_strap,
    input wire cgr_out_en_t out_en,
    input wire cgr_cfg_t    cfg
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    logic [2:0] strap_q;
    logic [1:0] age_q;

    // straps must stand still through reset, so capture them there
    always_ff @(posedge clk_sys)
        if (srst)
            strap_q <= freq_strap;

    // outputs only settle two edges after release
    always_ff @(posedge clk_sys)
        if (srst)
            age_q <= 2'h0;
        else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_release;
        $fell(srst) ##2 1'b1;
    endsequence

    property p_reset_en;
        s_release |-> out_en == 16'hFFFF;
    endproperty
    property p_reset_cfg;
        s_release |-> cfg == {5'h00, strap_q, 1'b0, strap_q, 3'h5, 4'h0};
    endproperty
    property p_reg_code;
        cfg.freq_code_origin |-> cfg.active_freq_code == cfg.processor_freq_code;
    endproperty
    property p_pin_code;
        age_q == 2'h3 && !cfg.freq_code_origin |-> cfg.active_freq_code == {1'b0, strap_q};
    endproperty
    property p_ack_rise;
        $rose(smb_dat_oe) |-> !smb_clk;
    endproperty
    property p_ack_fall;
        $fell(smb_dat_oe) |-> !smb_clk;
    endproperty
    property p_oe_hold;
        smb_clk && $past(smb_clk) |-> $stable(smb_dat_oe);
    endproperty
    property p_open_drain;
        smb_dat_out == 1'b0;
    endproperty
    property p_en_update;
        $changed(out_en[15:8]) |-> smb_clk;
    endproperty
    property p_cfg_update;
        $changed({cfg.graphics_spread_on, cfg.pcie_ref_spread_on, cfg.processor_spread_on,
                  cfg.output_voltage_code, cfg.pcie_ref_freq_code}) |-> smb_clk;
    endproperty

    ////////////////////////////////////////////////////////////////////////////////
    a_reset_en: assert property (p_reset_en) else $error("enables wrong after reset");
    a_reset_cfg: assert property (p_reset_cfg) else $error("config wrong after reset");
    a_reg_code: assert property (p_reg_code) else $error("register code not used");
    a_pin_code: assert property (p_pin_code) else $error("strap code not used");
    a_ack_rise: assert property (p_ack_rise) else $error("data pulled while clock high");
    a_ack_fall: assert property (p_ack_fall) else $error("data released while clock high");
    a_oe_hold: assert property (p_oe_hold) else $error("data moved in high phase");
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
    a_en_update: assert property (p_en_update) else $error("enables moved outside a write");
    a_cfg_update: assert property (p_cfg_update) else $error("config moved outside a write");
endmodule : cgr_regs_checker

bind cgr_regs cgr_regs_checker cgr_regs_checker_i (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .smb_clk     (smb_clk),
    .smb_dat_out (smb_dat_out),
    .smb_dat_oe  (smb_dat_oe),
    .freq_strap  (freq_strap),
    .out_en      (out_en),
    .cfg         (cfg)
);
`default_nettype wire

// ==== verif/cgr_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cgr_host_model
(
    // clock and shared data wire
    input wire logic clk_sys,
    input wire logic line,
    // driven pins
    output logic     scl,
    output logic     pull
);
    initial
    begin
        scl  = 1'b1;
        pull = 1'b0;
    end

    // quarter bit; long enough to cover the device's pin latency
    task automatic q;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : q

    task automatic start;
        pull = 1'b0;
        q();
        scl = 1'b1;
        q();
        pull = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask : start

    task automatic stop;
        pull = 1'b1;
        q();
        scl = 1'b1;
        q();
        pull = 1'b0;
        q();
    endtask : stop

    // data only moves in the low phase
    task automatic bit_io(input logic b, output logic s);
        pull = ~b;
        q();
        scl = 1'b1;
        q();
        s = line;
        q();
        scl = 1'b0;
        q();
    endtask : bit_io

    task automatic wr(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask : wr

    task automatic rd(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(last, s);
    endtask : rd
endmodule : cgr_host_model
`default_nettype wire

// ==== verif/cgr_regs_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module cgr_regs_test
    import cgr_pkg::*;
;
    logic [2:0]            strap = 3'h6;
    // identity values are arbitrary
    localparam logic [7:0] PID   = 8'hC3;
    localparam logic [7:0] REVMK = 8'h96;
    localparam logic [7:0] WMASK [8] = '{8'hFF, 8'hFF, 8'h3A, 8'hF5, 8'hE7, 8'hEF, 8'h00, 8'h00};

    logic        clk_sys;
    logic        srst;
    logic        smb_dat_oe;
    logic        scl;
    logic        pull;
    logic        line;
    logic        rq_a;
    logic        rq_b;
    logic        rq_c;
    cgr_out_en_t out_en;
    cgr_cfg_t    cfg;
    logic [7:0]  mem [8];
    logic [7:0]  wbuf [8];
    int          n_errors = 0;
    int          n_compared = 0;

    // pulled up unless someone pulls low
    assign line = ~(pull | smb_dat_oe);

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    cgr_regs #(.PART_ID(PID), .REV_CODE(REVMK[7:4]), .MAKER_CODE(REVMK[3:0])) cgr_regs_i (
        .clk_sys(clk_sys), .srst(srst), .smb_clk(scl), .smb_dat_in(line), .smb_dat_out(),
        .smb_dat_oe(smb_dat_oe), .freq_strap(strap), .clock_request_first_n(rq_a),
        .clock_request_second_n(rq_b), .clock_request_third_n(rq_c), .out_en(out_en), .cfg(cfg));

    cgr_host_model cgr_host_model_i (.clk_sys(clk_sys), .line(line), .scl(scl), .pull(pull));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk

    function automatic logic [15:0] exp_en();
        return {mem[1], mem[2][5] & (~mem[4][2] | ~rq_c), mem[2][4] & (~mem[4][1] | ~rq_c),
                mem[3][7] & (~mem[4][7] | ~rq_a), mem[3][6] & (~mem[4][6] | ~rq_a),
                mem[3][5] & (~mem[4][5] | ~rq_a), mem[3][4] & (~mem[2][3] | ~rq_b),
                mem[3][2] & (~mem[2][1] | ~rq_b), mem[3][0] & (~mem[4][0] | ~rq_c)};
    endfunction : exp_en

    function automatic logic [18:0] exp_cfg();
        return {mem[0], mem[0][7] ? mem[0][3:0] : {1'b0, strap}, mem[5][7:5], mem[5][3:0]};
    endfunction : exp_cfg

    task automatic chk_outs;
        repeat (6) @(posedge clk_sys);
        #1;
        chk("out_en", 32'(exp_en()), 32'(out_en));
        chk("cfg", 32'(exp_cfg()), 32'(cfg));
    endtask : chk_outs

    task automatic reset_dut;
        srst = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        mem = '{{5'h00, strap}, 8'hFF, 8'h30, 8'hFF, 8'h00, 8'hA0, PID, REVMK};
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : reset_dut

    // shadow keeps reserved and read-only bits
    task automatic blk_wr(input logic [7:0] adr, input logic [7:0] idx, input int n);
        logic       a;
        logic [2:0] i;
        cgr_host_model_i.start();
        cgr_host_model_i.wr(adr, a);
        chk("address ack", 32'(adr != 8'hD2), 32'(a));
        if (adr == 8'hD2)
        begin
            cgr_host_model_i.wr(idx, a);
            cgr_host_model_i.wr(8'(n), a);
            for (int k = 0; k < n; k++)
            begin
                cgr_host_model_i.wr(wbuf[k], a);
                chk("data ack", 32'h0, 32'(a));
                i = 3'(idx + 8'(k));
                mem[i] = (wbuf[k] & WMASK[i]) | (mem[i] & ~WMASK[i]);
            end
        end
        cgr_host_model_i.stop();
    endtask : blk_wr

    task automatic blk_rd(input logic [7:0] idx, input int n);
        logic       a;
        logic [7:0] b;
        cgr_host_model_i.start();
        cgr_host_model_i.wr(8'hD2, a);
        cgr_host_model_i.wr(idx, a);
        cgr_host_model_i.start();
        cgr_host_model_i.wr(8'hD3, a);
        chk("read ack", 32'h0, 32'(a));
        cgr_host_model_i.rd(1'b0, b);
        chk("count", 32'h08, 32'(b));
        for (int k = 0; k < n; k++)
        begin
            cgr_host_model_i.rd(k == n - 1, b);
            chk("read byte", 32'(mem[3'(idx + 8'(k))]), 32'(b));
        end
        cgr_host_model_i.stop();
    endtask : blk_rd

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        blk_rd(8'h00, 8);
        chk_outs();
    endtask : t_reset

    // all ones then all zeros, read-only bytes included
    task automatic t_fill;
        for (int v = 0; v < 2; v++)
        begin
            wbuf = '{default: (v == 0) ? 8'hFF : 8'h00};
            blk_wr(8'hD2, 8'h00, 8);
            blk_rd(8'h00, 8);
            chk_outs();
        end
    endtask : t_fill

    task automatic t_requests;
        wbuf = '{default: 8'hFF};
        blk_wr(8'hD2, 8'h00, 6);
        for (int r = 0; r < 8; r++)
        begin
            {rq_a, rq_b, rq_c} = 3'(r);
            chk_outs();
        end
        // cleared masters win over asserted requests
        wbuf[0] = 8'h00;
        blk_wr(8'hD2, 8'h03, 1);
        {rq_a, rq_b, rq_c} = 3'h0;
        chk_outs();
    endtask : t_requests

    task automatic t_spread;
        for (int k = 4; k < 8; k++)
        begin
            wbuf[0] = 8'(1 << k) | 8'h09;
            blk_wr(8'hD2, 8'h00, 1);
            chk_outs();
        end
        wbuf[0] = 8'h7C;
        blk_wr(8'hD2, 8'h00, 1);
        chk_outs();
    endtask : t_spread

    // foreign address is ignored; read starts mid-bank
    task automatic t_refuse;
        wbuf[0] = 8'h55;
        blk_wr(8'hD4, 8'h00, 1);
        blk_rd(8'h00, 1);
        blk_rd(8'h05, 3);
    endtask : t_refuse

    task automatic tally_and_finish;
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        srst = 1'b1;
        rq_a = 1'b1;
        rq_b = 1'b1;
        rq_c = 1'b1;
        reset_dut();
        t_reset();
        t_fill();
        t_requests();
        t_spread();
        t_refuse();
        // other straps so a hardwired code cannot pass
        strap = 3'h1;
        reset_dut();
        t_reset();
        tally_and_finish();
    end

    // whole run is about 17k cycles
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        tally_and_finish();
    end
endmodule : cgr_regs_test
`default_nettype wire
